// *** hdl/pep_panel.sv ***
// Panel keypad, parameter edit and monitor display logic.
//
// Functional notes
// - Mode key steps to next basic mode.
// - Short data press moves edit digit left.
// - Function and adjustment parameter classes supported.
// - Up/down step number; data shows value.
// - One-second data hold starts digit edit.
// - Up increments only the marked digit.
// - Short data press shifts flashing point left.
// - Long hold or mode key ends edit.
// - Function parameter change waits for restart.
// - Adjustment up/down change value, zero-padded.
// - Held up/down repeats adjustment quickly.
// - Data or mode returns adjust to number.
// - Long values shown in four-digit segments.
// - First data press shows lowest group.
// - Cursor continues into middle digit group.
// - Monitor mode selectable while motor runs.
// - Up/down select monitor, data toggles data.
// - Monitor numbers map to drive quantities.
// - Input segments 0-4 lit at low level.
// - Probe inputs on segments 6 and 7.
// - Output segment lit per optocoupler and inversion.
//
// The register offsets and the strobed register port were decided locally.
`timescale 1ns/1ps

module pep_panel #(
  parameter int unsigned TICK_CYCLES = pep_pkg::TICK_CYCLES_DFLT
) (
  input  wire logic                  core_clk_i,
  input  wire logic                  reset_n_i,
  input  wire pep_pkg::pep_key_type  keys_i,
  input  wire logic [4:0]            in_level_i,
  input  wire logic [1:0]            probe_i,
  input  wire logic [2:0]            opto_on_i,
  input  wire logic [39:0]           param_value_i,
  input  wire logic [39:0]           mon_value_i,
  input  wire logic [4:0]            reg_addr_i,
  input  wire logic [31:0]           reg_wdata_i,
  input  wire logic                  reg_wr_i,
  input  wire logic                  reg_rd_i,
  output logic [31:0]                reg_rdata_o,
  output pep_pkg::pep_disp_type      disp_o,
  output pep_pkg::pep_pwr_type       param_wr_o,
  output logic [11:0]                param_num_o,
  output logic [11:0]                mon_sel_o,
  output logic                       restart_pending_o
);

  ////////////////////////////////////////////////////////////////////////////
  // State.
  typedef struct packed {
    logic [3:0]             key1;
    logic [3:0]             key2;
    logic [3:0]             deb;
    logic [3:0]             deb_d;
    logic [3:0][3:0]        deb_cnt;
    logic [4:0]             in1;
    logic [4:0]             in2;
    logic [1:0]             pr1;
    logic [1:0]             pr2;
    logic [2:0]             op1;
    logic [2:0]             op2;
    logic [17:0]            tick_cnt;
    logic [10:0]            hold_cnt;
    logic                   hold_done;
    logic                   hold_seen;
    logic [9:0]             rep_cnt;
    logic                   rep_ev;
    logic [7:0]             blink_cnt;
    logic                   blink;
    pep_pkg::pep_mode_type  mode;
    pep_pkg::pep_view_type  view;
    logic [11:0]            pnum;
    logic [3:0]             midx;
    logic [11:0]            msel;
    logic [47:0]            val;
    logic                   is_func;
    logic                   is_long;
    logic                   pend;
    logic [3:0]             cur;
    logic [2:0]             inv;
    logic [11:0]            func_last;
    logic [31:0]            lim_lo;
    logic [31:0]            lim_hi;
    logic [31:0]            rdata;
    pep_pkg::pep_disp_type  disp;
    pep_pkg::pep_pwr_type   pwr;
  } pep_state_type;

  pep_state_type r;
  pep_state_type n;
  logic          tick;
  logic [3:0]    key_prs;
  logic          ev_mode;
  logic          ev_long;
  logic          ev_short;
  logic          ev_up;
  logic          ev_dn;

  // Steps a BCD number by one with wrap; used for numbers and values.
  function automatic logic [47:0] bcd_step(input logic [47:0] v,
                                           input logic        up);
    logic [47:0] res;
    logic        carry;
    res   = v;
    carry = 1'b1;
    for (int i = 0; i < 12; i++)
    begin
      if (carry)
      begin
        if (up && v[i*4 +: 4] == 4'h9)
          res[i*4 +: 4] = 4'h0;
        else if (!up && v[i*4 +: 4] == 4'h0)
          res[i*4 +: 4] = 4'h9;
        else
        begin
          res[i*4 +: 4] = up ? v[i*4 +: 4] + 4'h1 : v[i*4 +: 4] - 4'h1;
          carry         = 1'b0;
        end
      end
    end
    return res;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Key events.
  assign tick     = r.tick_cnt == 18'(TICK_CYCLES - 1);
  assign key_prs  = r.deb & ~r.deb_d;
  assign ev_mode  = key_prs[pep_pkg::KEY_MODE];
  assign ev_long  = r.hold_done & ~r.hold_seen & r.deb[pep_pkg::KEY_DATA];
  // A release after the hold fired is not a short press.
  assign ev_short = ~r.deb[pep_pkg::KEY_DATA] & r.deb_d[pep_pkg::KEY_DATA]
                    & ~r.hold_done;
  assign ev_up    = key_prs[pep_pkg::KEY_UP] | (r.view == pep_pkg::VIEW_ADJ
                    & r.rep_ev & r.deb[pep_pkg::KEY_UP]);
  assign ev_dn    = key_prs[pep_pkg::KEY_DOWN] | (r.view == pep_pkg::VIEW_ADJ
                    & r.rep_ev & r.deb[pep_pkg::KEY_DOWN]);

  ////////////////////////////////////////////////////////////////////////////
  // Next state.
  always_comb
  begin
    logic [47:0] stp;
    logic [3:0]  dig;
    logic        commit;
    logic [2:0]  pos;
    stp    = '0;
    dig    = '0;
    commit = 1'b0;
    pos    = '0;
    n      = r;
    n.pwr.strobe = 1'b0;
    n.rep_ev     = 1'b0;
    n.key1  = keys_i;
    n.key2  = r.key1;
    n.in1   = in_level_i;
    n.in2   = r.in1;
    n.pr1   = probe_i;
    n.pr2   = r.pr1;
    n.op1   = opto_on_i;
    n.op2   = r.op1;
    n.deb_d = r.deb;
    n.tick_cnt = tick ? '0 : r.tick_cnt + 18'h1;
    // Timebase-driven debounce; a bounce restarts the stable count.
    for (int i = 0; i < 4; i++)
    begin
      if (r.key2[i] == r.deb[i])
        n.deb_cnt[i] = '0;
      else if (tick)
      begin
        if (r.deb_cnt[i] == 4'(pep_pkg::DEB_TICKS - 1))
        begin
          n.deb[i]     = r.key2[i];
          n.deb_cnt[i] = '0;
        end
        else
          n.deb_cnt[i] = r.deb_cnt[i] + 4'h1;
      end
    end
    n.hold_seen = r.hold_done;
    if (~|r.deb || |key_prs)
    begin
      n.hold_cnt  = '0;
      n.hold_done = 1'b0;
      n.rep_cnt   = '0;
    end
    else if (tick)
    begin
      if (!r.hold_done)
      begin
        if (r.hold_cnt == 11'(pep_pkg::HOLD_TICKS - 1))
          n.hold_done = 1'b1;
        else
          n.hold_cnt = r.hold_cnt + 11'h1;
      end
      else if (r.rep_cnt == 10'(pep_pkg::REP_TICKS - 1))
      begin
        n.rep_cnt = '0;
        n.rep_ev  = 1'b1;
      end
      else
        n.rep_cnt = r.rep_cnt + 10'h1;
    end
    if (tick)
    begin
      if (r.blink_cnt == 8'(pep_pkg::BLINK_TICKS - 1))
      begin
        n.blink_cnt = '0;
        n.blink     = ~r.blink;
      end
      else
        n.blink_cnt = r.blink_cnt + 8'h1;
    end
    // Register port; unmapped reads return zero.
    if (reg_wr_i)
    begin
      case (reg_addr_i)
        pep_pkg::OFS_CTRL:      n.inv       = reg_wdata_i[2:0];
        pep_pkg::OFS_FUNC_LAST: n.func_last = reg_wdata_i[11:0];
        pep_pkg::OFS_LIM_LO:    n.lim_lo    = reg_wdata_i;
        pep_pkg::OFS_LIM_HI:    n.lim_hi    = reg_wdata_i;
        default:                n.inv       = r.inv;
      endcase
    end
    n.rdata = '0;
    if (reg_rd_i)
    begin
      case (reg_addr_i)
        pep_pkg::OFS_CTRL:      n.rdata[2:0]  = r.inv;
        pep_pkg::OFS_FUNC_LAST: n.rdata[11:0] = r.func_last;
        pep_pkg::OFS_LIM_LO:    n.rdata       = r.lim_lo;
        pep_pkg::OFS_LIM_HI:    n.rdata       = r.lim_hi;
        pep_pkg::OFS_STATUS:
        begin
          n.rdata[pep_pkg::STAT_MODE_LSB +: 4] = r.mode;
          n.rdata[pep_pkg::STAT_VIEW_LSB +: 4] = r.view;
          n.rdata[pep_pkg::STAT_CUR_LSB +: 4]  = r.cur;
          n.rdata[pep_pkg::STAT_LONG_BIT]      = r.is_long;
          n.rdata[pep_pkg::STAT_PEND_BIT]      = r.pend;
        end
        default:                n.rdata = '0;
      endcase
    end
    // Panel sequencing; the mode key outranks every other key.
    if (ev_mode)
    begin
      if (r.view == pep_pkg::VIEW_EDIT)
      begin
        n.view = pep_pkg::VIEW_VAL;
        commit = 1'b1;
      end
      else if (r.view == pep_pkg::VIEW_ADJ)
      begin
        n.view = pep_pkg::VIEW_NUM;
        commit = 1'b1;
      end
      else
      begin
        // No interlock with motor motion, so monitoring never stops it.
        n.view = pep_pkg::VIEW_NUM;
        unique case (r.mode)
          pep_pkg::MODE_STATUS: n.mode = pep_pkg::MODE_PARAM;
          pep_pkg::MODE_PARAM:  n.mode = pep_pkg::MODE_UTIL;
          pep_pkg::MODE_UTIL:   n.mode = pep_pkg::MODE_MON;
          pep_pkg::MODE_MON:    n.mode = pep_pkg::MODE_STATUS;
        endcase
      end
    end
    else
    begin
      unique case (r.view)
        pep_pkg::VIEW_NUM:
        begin
          if (r.mode == pep_pkg::MODE_PARAM)
          begin
            if (ev_up || ev_dn)
            begin
              stp    = bcd_step({36'h0, r.pnum}, ev_up);
              n.pnum = stp[11:0];
            end
            else if (ev_short)
            begin
              n.val     = {8'h0, param_value_i};
              n.is_func = r.pnum <= r.func_last;
              n.is_long = |param_value_i[39:20];
              n.cur     = '0;
              n.view    = (n.is_func || n.is_long) ? pep_pkg::VIEW_VAL
                                                   : pep_pkg::VIEW_ADJ;
            end
          end
          else if (r.mode == pep_pkg::MODE_MON)
          begin
            if (ev_up)
              n.midx = (r.midx == pep_pkg::MON_LAST) ? 4'h0
                                                     : r.midx + 4'h1;
            else if (ev_dn)
              n.midx = (r.midx == 4'h0) ? pep_pkg::MON_LAST
                                        : r.midx - 4'h1;
            else if (ev_short)
              n.view = pep_pkg::VIEW_VAL;
          end
        end
        pep_pkg::VIEW_VAL:
        begin
          if (ev_short)
            n.view = pep_pkg::VIEW_NUM;
          else if (ev_long && r.mode == pep_pkg::MODE_PARAM)
          begin
            n.view = pep_pkg::VIEW_EDIT;
            n.cur  = '0;
          end
        end
        pep_pkg::VIEW_EDIT:
        begin
          dig = r.val[{r.cur, 2'b00} +: 4];
          if (ev_up)
            n.val[{r.cur, 2'b00} +: 4] = (dig == 4'h9) ? 4'h0
                                                       : dig + 4'h1;
          else if (ev_dn)
            n.val[{r.cur, 2'b00} +: 4] = (dig == 4'h0) ? 4'h9 : dig - 4'h1;
          else if (ev_short)
            n.cur = (r.cur == (r.is_long ? pep_pkg::CUR_LAST_LONG
                                         : pep_pkg::CUR_LAST_SHORT))
                    ? 4'h0 : r.cur + 4'h1;
          else if (ev_long)
          begin
            n.view = pep_pkg::VIEW_VAL;
            commit = 1'b1;
          end
        end
        pep_pkg::VIEW_ADJ:
        begin
          if (ev_up || ev_dn)
          begin
            // Out-of-range steps are dropped, so wrap never escapes limits.
            stp = bcd_step(r.val, ev_up);
            if (stp >= {16'h0, r.lim_lo} && stp <= {16'h0, r.lim_hi})
              n.val = stp;
          end
          else if (ev_short)
          begin
            n.view = pep_pkg::VIEW_NUM;
            commit = 1'b1;
          end
        end
      endcase
    end
    if (commit)
    begin
      n.pwr.strobe   = 1'b1;
      n.pwr.deferred = r.is_func;
      n.pwr.num      = r.pnum;
      n.pwr.value    = r.val[39:0];
      n.pend         = r.pend | r.is_func;
    end
    n.msel = pep_pkg::MON_NUM[n.midx];
    // Display image of the present state.
    n.disp.digit = {5{pep_pkg::GLYPH_BLANK}};
    n.disp.dp    = '0;
    n.disp.seg   = '0;
    n.disp.raw   = 1'b0;
    pos = r.is_long ? {1'b0, r.cur[1:0]} : r.cur[2:0];
    unique case (r.mode)
      pep_pkg::MODE_STATUS: n.disp.digit = {5{pep_pkg::GLYPH_DASH}};
      pep_pkg::MODE_UTIL:
        n.disp.digit = {pep_pkg::GLYPH_F, {4{pep_pkg::GLYPH_DASH}}};
      pep_pkg::MODE_PARAM:
      begin
        if (r.view == pep_pkg::VIEW_NUM)
          n.disp.digit = {pep_pkg::GLYPH_P, pep_pkg::GLYPH_N, r.pnum};
        else if (r.is_long)
          n.disp.digit = {{2'b00, r.cur[3:2]},
                          r.val[{r.cur[3:2], 4'h0} +: 16]};
        else
          n.disp.digit = r.val[19:0];
        if (r.view == pep_pkg::VIEW_EDIT)
          n.disp.dp[pos] = r.blink;
      end
      pep_pkg::MODE_MON:
      begin
        if (r.view == pep_pkg::VIEW_NUM)
          n.disp.digit = {pep_pkg::GLYPH_U, pep_pkg::GLYPH_N, r.msel};
        else if (r.midx == pep_pkg::MON_IN_IDX)
        begin
          n.disp.raw      = 1'b1;
          n.disp.seg[4:0] = ~r.in2;
        end
        else if (r.midx == pep_pkg::MON_PROBE_IDX)
        begin
          n.disp.raw      = 1'b1;
          n.disp.seg[7:6] = r.pr2;
        end
        else if (r.midx == pep_pkg::MON_OUT_IDX)
        begin
          n.disp.raw      = 1'b1;
          n.disp.seg[2:0] = r.op2 ^ r.inv;
        end
        else
          n.disp.digit = mon_value_i[19:0];
      end
    endcase
  end

  always_ff @(posedge core_clk_i)
  begin
    if (!reset_n_i)
    begin
      r           <= '0;
      r.mode      <= pep_pkg::MODE_STATUS;
      r.view      <= pep_pkg::VIEW_NUM;
      r.msel      <= pep_pkg::MON_NUM[0];
      r.inv       <= pep_pkg::CTRL_INV_RST;
      r.func_last <= pep_pkg::FUNC_LAST_RST;
      r.lim_lo    <= pep_pkg::LIM_LO_RST;
      r.lim_hi    <= pep_pkg::LIM_HI_RST;
    end
    else
      r <= n;
  end

  assign reg_rdata_o       = r.rdata;
  assign disp_o            = r.disp;
  assign param_wr_o        = r.pwr;
  assign param_num_o       = r.pnum;
  assign mon_sel_o         = r.msel;
  assign restart_pending_o = r.pend;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!reset_n_i);

  a_mode_step_ok: assert property (
    (ev_mode && r.view == pep_pkg::VIEW_NUM) |=>
    r.mode == {$past(r.mode[2:0]), $past(r.mode[3])})
    else $error("mode key did not advance the mode");
  a_pnum_step_ok: assert property (
    (!ev_mode && r.view == pep_pkg::VIEW_NUM && r.mode == pep_pkg::MODE_PARAM
     && key_prs[pep_pkg::KEY_UP]) |=> r.pnum != $past(r.pnum))
    else $error("up key did not step the parameter number");
  a_edit_enter_ok: assert property (
    (!ev_mode && ev_long && r.view == pep_pkg::VIEW_VAL
     && r.mode == pep_pkg::MODE_PARAM) |=>
    r.view == pep_pkg::VIEW_EDIT && r.cur == 4'h0)
    else $error("long data hold did not start digit edit");
  a_digit_inc_ok: assert property (
    (!ev_mode && ev_up && r.view == pep_pkg::VIEW_EDIT) |=>
    (r.val ^ $past(r.val)) >> {$past(r.cur), 2'b00} != 48'h0
    && (r.val ^ $past(r.val)) >> {$past(r.cur), 2'b00} < 48'h10)
    else $error("digit edit changed the wrong digit");
  a_cursor_left_ok: assert property (
    (!ev_mode && ev_short && r.view == pep_pkg::VIEW_EDIT
     && r.cur == 4'h0) |=> r.cur == 4'h1)
    else $error("short data press did not move the cursor");
  a_edit_exit_ok: assert property (
    (ev_mode && r.view == pep_pkg::VIEW_EDIT) |=>
    r.view == pep_pkg::VIEW_VAL && param_wr_o.strobe
    ##1 !param_wr_o.strobe)
    else $error("edit exit did not commit once");
  a_pad_view_ok: assert property (
    (r.view == pep_pkg::VIEW_ADJ && r.mode == pep_pkg::MODE_PARAM
     && !r.is_long) |=> disp_o.digit == $past(r.val[19:0]))
    else $error("adjust value not shown zero padded");
  a_adj_return_ok: assert property (
    (!ev_mode && ev_short && r.view == pep_pkg::VIEW_ADJ) |=>
    r.view == pep_pkg::VIEW_NUM && param_wr_o.strobe)
    else $error("data key did not leave adjust view");
  a_input_seg_ok: assert property (
    (r.mode == pep_pkg::MODE_MON && r.view == pep_pkg::VIEW_VAL
     && r.midx == pep_pkg::MON_IN_IDX) |=>
    disp_o.raw && disp_o.seg[4:0] == ~$past(r.in2))
    else $error("input monitor segments wrong");
  a_probe_seg_ok: assert property (
    (r.mode == pep_pkg::MODE_MON && r.view == pep_pkg::VIEW_VAL
     && r.midx == pep_pkg::MON_PROBE_IDX) |=>
    disp_o.seg == {$past(r.pr2), 6'h00})
    else $error("probe monitor segments wrong");
  a_out_seg_ok: assert property (
    (r.mode == pep_pkg::MODE_MON && r.view == pep_pkg::VIEW_VAL
     && r.midx == pep_pkg::MON_OUT_IDX) |=>
    disp_o.seg[2:0] == ($past(r.op2) ^ $past(r.inv)))
    else $error("output monitor segments wrong");
  a_hold_time_ok: assert property (
    $rose(r.hold_done) |->
    $past(r.hold_cnt) == 11'(pep_pkg::HOLD_TICKS - 1) && $past(tick))
    else $error("hold detected before one second");

endmodule // pep_panel

// *** hdl/pep_pkg.sv ***
// Constants and carrier types of the panel parameter edit and monitor block.
package pep_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Timebase and key timing.
  localparam int unsigned CLK_PERIOD_PS    = 5000;
  localparam int unsigned TICK_PERIOD_US   = 1000;
  localparam int unsigned TICK_CYCLES_DFLT =
    TICK_PERIOD_US * 1000000 / CLK_PERIOD_PS;
  localparam int unsigned HOLD_TIME_MS     = 1000;
  localparam int unsigned DEB_TIME_MS      = 10;
  localparam int unsigned REP_TIME_MS      = 50;
  localparam int unsigned BLINK_TIME_MS    = 250;
  localparam int unsigned HOLD_TICKS  =
    (HOLD_TIME_MS * 1000 + TICK_PERIOD_US - 1) / TICK_PERIOD_US;
  localparam int unsigned DEB_TICKS   =
    (DEB_TIME_MS * 1000 + TICK_PERIOD_US - 1) / TICK_PERIOD_US;
  localparam int unsigned REP_TICKS   = REP_TIME_MS * 1000 / TICK_PERIOD_US;
  localparam int unsigned BLINK_TICKS = BLINK_TIME_MS * 1000 / TICK_PERIOD_US;

  ////////////////////////////////////////////////////////////////////////////
  // Register map, reset values and status fields.
  localparam logic [4:0]  OFS_CTRL      = 5'h00;
  localparam logic [4:0]  OFS_FUNC_LAST = 5'h04;
  localparam logic [4:0]  OFS_LIM_LO    = 5'h08;
  localparam logic [4:0]  OFS_LIM_HI    = 5'h0C;
  localparam logic [4:0]  OFS_STATUS    = 5'h10;
  localparam logic [2:0]  CTRL_INV_RST  = 3'h0;
  localparam logic [11:0] FUNC_LAST_RST = 12'h099;
  localparam logic [31:0] LIM_LO_RST    = 32'h00000000;
  localparam logic [31:0] LIM_HI_RST    = 32'h99999999;
  localparam int unsigned STAT_MODE_LSB = 0;
  localparam int unsigned STAT_VIEW_LSB = 4;
  localparam int unsigned STAT_CUR_LSB  = 8;
  localparam int unsigned STAT_LONG_BIT = 12;
  localparam int unsigned STAT_PEND_BIT = 13;

  ////////////////////////////////////////////////////////////////////////////
  // Keys, glyphs, cursor limits and monitor numbers.
  localparam int unsigned KEY_MODE = 0;
  localparam int unsigned KEY_UP   = 1;
  localparam int unsigned KEY_DOWN = 2;
  localparam int unsigned KEY_DATA = 3;
  localparam logic [3:0] GLYPH_DASH  = 4'hA;
  localparam logic [3:0] GLYPH_P     = 4'hB;
  localparam logic [3:0] GLYPH_U     = 4'hC;
  localparam logic [3:0] GLYPH_N     = 4'hD;
  localparam logic [3:0] GLYPH_F     = 4'hE;
  localparam logic [3:0] GLYPH_BLANK = 4'hF;
  localparam logic [3:0] CUR_LAST_SHORT = 4'h4;
  localparam logic [3:0] CUR_LAST_LONG  = 4'h9;
  localparam logic [3:0] MON_LAST      = 4'hE;
  localparam logic [3:0] MON_IN_IDX    = 4'h3;
  localparam logic [3:0] MON_PROBE_IDX = 4'h4;
  localparam logic [3:0] MON_OUT_IDX   = 4'h5;
  localparam logic [14:0][11:0] MON_NUM = {
    12'h022, 12'h021, 12'h019, 12'h016, 12'h015, 12'h013, 12'h011, 12'h009,
    12'h008, 12'h007, 12'h006, 12'h005, 12'h004, 12'h003, 12'h000};

  ////////////////////////////////////////////////////////////////////////////
  // Types.
  typedef enum logic [3:0] {
    MODE_STATUS = 4'h1, MODE_PARAM = 4'h2, MODE_UTIL = 4'h4, MODE_MON = 4'h8
  } pep_mode_type;
  typedef enum logic [3:0] {
    VIEW_NUM = 4'h1, VIEW_VAL = 4'h2, VIEW_EDIT = 4'h4, VIEW_ADJ = 4'h8
  } pep_view_type;
  typedef struct packed {
    logic data;
    logic down;
    logic up;
    logic mode;
  } pep_key_type;
  typedef struct packed {
    logic [4:0][3:0] digit;
    logic [4:0]      dp;
    logic [7:0]      seg;
    logic            raw;
  } pep_disp_type;
  typedef struct packed {
    logic        strobe;
    logic        deferred;
    logic [11:0] num;
    logic [39:0] value;
  } pep_pwr_type;

endpackage

// *** tb/pep_operator.sv ***
// Operator model that presses one panel key at a time.
`timescale 1ns/1ps

module pep_operator (
  input  wire logic            core_clk_i,
  input  wire logic            start_i,
  input  wire logic [1:0]      key_i,
  input  wire logic [15:0]     len_i,
  output pep_pkg::pep_key_type keys_o,
  output logic                 busy_o
);
  logic [15:0] hold_r = 16'h0000;
  logic [7:0]  gap_r  = 8'h00;
  logic [1:0]  key_r  = 2'h0;

  initial busy_o = 1'b0;
  // A released key idles low; the gap lets the debounced release settle.
  always @(posedge core_clk_i)
  begin
    if (start_i)
    begin
      key_r  <= key_i;
      hold_r <= len_i;
      gap_r  <= 8'hC8;
      busy_o <= 1'b1;
    end
    else if (hold_r != 16'h0000) hold_r <= hold_r - 16'h0001;
    else if (gap_r != 8'h00) gap_r <= gap_r - 8'h01;
    else busy_o <= 1'b0;
  end
  assign keys_o = pep_pkg::pep_key_type'((hold_r != 16'h0000) ?
                                         (4'h1 << key_r) : 4'h0);
endmodule // pep_operator

// *** tb/tb_pep_panel.sv ***
// Testbench of the panel parameter edit and monitor block.
`timescale 1ns/1ps

module tb_pep_panel;
  logic                  core_clk_i = 1'b0;
  logic                  reset_n_i  = 1'b0;
  logic                  start = 1'b0;
  logic [1:0]            key   = 2'h0;
  logic [15:0]           len   = 16'h0000;
  logic                  busy;
  pep_pkg::pep_key_type  keys;
  logic [4:0]            in_lvl = 5'h00;
  logic [1:0]            probe  = 2'h0;
  logic [2:0]            opto   = 3'h0;
  logic [39:0]           pval   = 40'h0;
  logic [39:0]           mval   = 40'h0;
  logic [4:0]            addr   = 5'h00;
  logic [31:0]           wdata  = 32'h0;
  logic                  wr = 1'b0;
  logic                  rd = 1'b0;
  logic [31:0]           rdata;
  logic [31:0]           st;
  pep_pkg::pep_disp_type disp;
  pep_pkg::pep_pwr_type  pwr;
  pep_pkg::pep_pwr_type  got_wr;
  logic [11:0]           pnum;
  logic [11:0]           msel;
  logic                  pend;
  int bad_count = 0;
  int compares = 0;
  int n_wr = 0;
  int exp_num = 0;

  initial forever #2.5 core_clk_i = ~core_clk_i;
  always @(posedge core_clk_i) if (pwr.strobe === 1'b1)
  begin
    got_wr <= pwr;
    n_wr++;
  end

  pep_operator u_pep_operator (.core_clk_i(core_clk_i), .start_i(start),
    .key_i(key), .len_i(len), .keys_o(keys), .busy_o(busy));
  pep_panel #(.TICK_CYCLES(4)) u_pep_panel (.core_clk_i(core_clk_i),
    .reset_n_i(reset_n_i), .keys_i(keys), .in_level_i(in_lvl),
    .probe_i(probe), .opto_on_i(opto), .param_value_i(pval),
    .mon_value_i(mval), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .disp_o(disp),
    .param_wr_o(pwr), .param_num_o(pnum), .mon_sel_o(msel),
    .restart_pending_o(pend));

  ////////////////////////////////////////////////////////////////////////////
  task chk(input string nm, input logic [39:0] e, input logic [39:0] g);
    compares++;
    if (g !== e)
    begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task rdr(input logic [4:0] a);
    @(posedge core_clk_i) addr <= a;
    rd <= 1'b1;
    @(posedge core_clk_i) rd <= 1'b0;
    #1 st = rdata;
  endtask
  task press(input int k, input int n);
    @(posedge core_clk_i) start <= 1'b1;
    key <= k[1:0];
    len <= n[15:0];
    @(posedge core_clk_i) start <= 1'b0;
    #1;
    for (int i = 0; i < 6000 && busy; i++) @(posedge core_clk_i);
  endtask
  task final_report;
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Short presses clear debounce but stay far below the long hold.
  initial
  begin
    void'($urandom(54659));
    repeat (8) @(posedge core_clk_i);
    reset_n_i <= 1'b1;
    in_lvl <= 5'($urandom);
    probe <= 2'($urandom);
    opto <= 3'($urandom);
    mval <= 40'({$urandom, $urandom});
    @(posedge core_clk_i) addr <= pep_pkg::OFS_CTRL;
    wdata <= 32'h00000005;
    wr <= 1'b1;
    @(posedge core_clk_i) wr <= 1'b0;
    rdr(pep_pkg::OFS_CTRL); chk("ctrl", 40'h5, st);
    rdr(5'h1C); chk("unmapped", 40'h0, st);
    $display("test registers done");
    press(0, 150); rdr(pep_pkg::OFS_STATUS);
    chk("mode", 40'h2, st[3:0]);
    repeat (3) begin press(1, 150); exp_num++; end
    chk("pnum", exp_num, pnum);
    press(3, 150); rdr(pep_pkg::OFS_STATUS); chk("view", 40'h2, st[7:4]);
    press(3, 4200); rdr(pep_pkg::OFS_STATUS);
    chk("edit", 40'h04, st[11:4]);
    repeat (2) press(1, 150);
    chk("digit", 40'h2, disp.digit[0]);
    press(3, 150); rdr(pep_pkg::OFS_STATUS); chk("cur", 40'h1, st[11:8]);
    press(3, 4200); chk("writes", 40'h1, n_wr);
    chk("wval", 40'h2, got_wr.value);
    chk("wnum", exp_num, got_wr.num);
    chk("defer", 40'h1, {got_wr.deferred, pend} == 2'b11);
    $display("test edit done");
    repeat (2) press(0, 150); rdr(pep_pkg::OFS_STATUS);
    chk("mon", 40'h8, st[3:0]);
    repeat (3) press(1, 150);
    chk("msel", pep_pkg::MON_NUM[3], msel);
    press(3, 150); chk("raw", 40'h1, disp.raw);
    chk("inseg", {35'h0, ~in_lvl}, disp.seg[4:0]);
    press(3, 150);
    chk("back", 40'h0, disp.raw);
    press(1, 150);
    press(3, 150);
    chk("prseg", {32'h0, probe, 6'h00}, disp.seg);
    press(3, 150);
    press(1, 150);
    press(3, 150);
    chk("outseg", {37'h0, opto ^ 3'h5}, disp.seg[2:0]);
    $display("test monitor done");
    // Lowering the function range turns number 003 into an adjustment.
    repeat (2) press(0, 150);
    pval <= 40'h0000000100;
    @(posedge core_clk_i) addr <= pep_pkg::OFS_FUNC_LAST;
    wdata <= 32'h00000000;
    wr <= 1'b1;
    @(posedge core_clk_i) wr <= 1'b0;
    rdr(pep_pkg::OFS_FUNC_LAST);
    chk("flast", 40'h0, st);
    press(3, 150);
    rdr(pep_pkg::OFS_STATUS);
    chk("adj", 40'h82, st[7:0]);
    press(2, 150);
    chk("pad", 40'h00099, disp.digit);
    press(2, 5000);
    chk("fast", 40'h1, disp.digit < 20'h00098);
    press(3, 150);
    chk("adjwr", 40'h2, n_wr);
    chk("adjdef", 40'h0, got_wr.deferred);
    chk("adjnum", pep_pkg::GLYPH_P, disp.digit[4]);
    $display("test adjust done");
    pval <= 40'h0041943040;
    press(3, 150);
    chk("low", 40'h03040, disp.digit);
    press(3, 4200);
    repeat (4) press(3, 150);
    chk("mid", 40'h14194, disp.digit);
    $display("test long done");
    final_report;
  end
  initial
  begin
    #300000;
    bad_count++;
    final_report;
  end
endmodule // tb_pep_panel
